// >>> common/sfsp_defs.vh
/*
  Shared constants of the synchronous flow-through SRAM port: widths,
  lane layout, reset values and strap encodings.
  Assumes it is included by bare name from the design files.
*/
`ifndef SFSP_DEFS_VH
`define SFSP_DEFS_VH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define SFSP_AW          20
`define SFSP_MEM_AW      10
`define SFSP_DW          16
`define SFSP_PW          2
`define SFSP_LANES       2
`define SFSP_LANE_W      8
`define SFSP_WORD_W      18
`define SFSP_CNT_W       2
`define SFSP_ENTRY_W     30
`define SFSP_BUF_DEPTH   2

// ----------------------------------------------------------------
// Values
// ----------------------------------------------------------------
`define SFSP_CNT_ZERO    2'h0
`define SFSP_CNT_ONE     2'h1
`define SFSP_BUF_CNT_ZERO 2'h0
`define SFSP_BUF_CNT_ONE 2'h1
`define SFSP_BUF_CNT_FULL 2'h2
`define SFSP_MODE_LINEAR 1'h0
`define SFSP_MODE_ILV    1'h1
`define SFSP_ST_DESEL    1'h0
`define SFSP_ST_ACTIVE   1'h1

`endif

// >>> logic/sfsp_buf.v
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
`include "sfsp_defs.vh"

module sfsp_buf #(
  parameter WIDTH = `SFSP_ENTRY_W
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);

  reg [WIDTH-1:0] mem_q [0:`SFSP_BUF_DEPTH-1];
  reg             wr_ptr_q;
  reg             rd_ptr_q;
  reg [1:0]       cnt_q;
  reg [1:0]       cnt_d;
  reg             ready_q;
  wire            push;
  wire            pop;

  assign push        = in_valid_i && ready_q;
  assign pop         = out_ready_i && (cnt_q != `SFSP_BUF_CNT_ZERO);
  assign in_ready_o  = ready_q;
  assign out_valid_o = (cnt_q != `SFSP_BUF_CNT_ZERO);
  assign out_data_o  = mem_q[rd_ptr_q];

  always @* begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + `SFSP_BUF_CNT_ONE;
    end else if (pop && !push) begin
      cnt_d = cnt_q - `SFSP_BUF_CNT_ONE;
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_q <= 1'h0;
      rd_ptr_q <= 1'h0;
      cnt_q    <= `SFSP_BUF_CNT_ZERO;
      ready_q  <= 1'h1;
    end else begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      cnt_q   <= cnt_d;
      ready_q <= (cnt_d != `SFSP_BUF_CNT_FULL);
    end
  end

  always @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

endmodule

// >>> logic/sfsp_port.v
/*
  Host-facing port of a synchronous flow-through burst SRAM with a small
  storage array, burst counter, byte-lane writes and a write buffer.
  Assumes all inputs, output enable and sleep included, are synchronous to
  clk_i; the pin-level pull-up and pull-down are the board's or bench's.
*/
`timescale 1ns/1ps
`include "sfsp_defs.vh"

module sfsp_port (
  input  wire                   clk_i,
  input  wire                   rst_i,
  input  wire [`SFSP_AW-1:0]    addr_i,
  input  wire                   processor_addr_strobe_n_i,
  input  wire                   controller_addr_strobe_n_i,
  input  wire                   burst_step_n_i,
  input  wire                   primary_select_n_i,
  input  wire                   secondary_select_i,
  input  wire                   tertiary_select_n_i,
  input  wire                   all_bytes_write_n_i,
  input  wire                   byte_write_qualifier_n_i,
  input  wire [`SFSP_LANES-1:0] byte_lane_write_n_i,
  input  wire                   out_enable_n_i,
  input  wire                   sleep_request_i,
  input  wire                   burst_order_strap_i,
  input  wire [`SFSP_DW-1:0]    dq_i,
  output wire [`SFSP_DW-1:0]    dq_o,
  output wire                   dq_oe_o,
  input  wire [`SFSP_PW-1:0]    parity_io_i,
  output wire [`SFSP_PW-1:0]    parity_io_o,
  output wire                   parity_io_oe_o,
  output wire                   write_ready_o,
  output wire                   selected_o,
  output wire                   sleeping_o
);

  // ----------------------------------------------------------------
  // Burst address
  // ----------------------------------------------------------------
  function [`SFSP_CNT_W-1:0] burst_low;
    input                   mode;
    input [`SFSP_CNT_W-1:0] base;
    input [`SFSP_CNT_W-1:0] step;
    begin
      if (mode == `SFSP_MODE_LINEAR) begin
        burst_low = base + step;
      end else begin
        burst_low = base ^ step;
      end
    end
  endfunction

  reg                    state_q;
  reg                    state_d;
  reg [`SFSP_AW-1:0]     addr_q;
  reg [`SFSP_AW-1:0]     addr_d;
  reg [`SFSP_CNT_W-1:0]  step_q;
  reg [`SFSP_CNT_W-1:0]  step_d;
  reg                    mode_q;
  reg [`SFSP_WORD_W-1:0] dout_q;
  reg                    oe_q;
  reg                    sleep_q;
  reg [`SFSP_WORD_W-1:0] mem_q [0:(1<<`SFSP_MEM_AW)-1];

  wire                   proc_seen;
  wire                   ctrl_seen;
  wire                   start;
  wire                   enables_ok;
  wire [`SFSP_AW-1:0]    eff_addr;
  wire                   write_now;
  wire [`SFSP_LANES-1:0] lane_we;
  wire [`SFSP_WORD_W-1:0] word_in;
  wire [`SFSP_WORD_W-1:0] lane_bits;
  wire [`SFSP_ENTRY_W-1:0] entry_in;
  wire [`SFSP_ENTRY_W-1:0] entry_out;
  wire                   entry_valid;
  wire                   buf_ready;
  wire                   drain_ok;

  // ----------------------------------------------------------------
  // Strobe decode
  // ----------------------------------------------------------------
  assign enables_ok = !primary_select_n_i && secondary_select_i && !tertiary_select_n_i;
  assign proc_seen  = !processor_addr_strobe_n_i && !primary_select_n_i;
  assign ctrl_seen  = !controller_addr_strobe_n_i && !proc_seen;
  assign start      = proc_seen || ctrl_seen;

  always @* begin
    state_d = state_q;
    addr_d  = addr_q;
    step_d  = step_q;
    case (state_q)
      `SFSP_ST_DESEL: begin
        if (start && enables_ok) begin
          state_d = `SFSP_ST_ACTIVE;
          addr_d  = addr_i;
          step_d  = `SFSP_CNT_ZERO;
        end
      end
      `SFSP_ST_ACTIVE: begin
        if (start && !enables_ok) begin
          state_d = `SFSP_ST_DESEL;
        end else if (start) begin
          addr_d = addr_i;
          step_d = `SFSP_CNT_ZERO;
        end else if (!burst_step_n_i) begin
          step_d = step_q + `SFSP_CNT_ONE;
        end
      end
      default: begin
        state_d = `SFSP_ST_DESEL;
      end
    endcase
  end

  // Base low bits come from the captured address, step from the counter
  assign eff_addr = {addr_d[`SFSP_AW-1:`SFSP_CNT_W],
                     burst_low(mode_q, addr_d[`SFSP_CNT_W-1:0], step_d)};

  // ----------------------------------------------------------------
  // Write lanes
  // ----------------------------------------------------------------
  assign word_in   = {parity_io_i, dq_i};
  assign write_now = (state_d == `SFSP_ST_ACTIVE) &&
                     (!all_bytes_write_n_i || (!byte_write_qualifier_n_i &&
                      (byte_lane_write_n_i != {`SFSP_LANES{1'h1}})));

  genvar g;
  generate
    for (g = 0; g < `SFSP_LANES; g = g + 1) begin : g_lane
      assign lane_we[g] = !all_bytes_write_n_i ||
                          (!byte_write_qualifier_n_i && !byte_lane_write_n_i[g]);
    end
  endgenerate

  assign entry_in = {eff_addr[`SFSP_MEM_AW-1:0], lane_we, word_in};

  sfsp_buf #(
    .WIDTH (`SFSP_ENTRY_W)
  ) u_wbuf (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (write_now),
    .in_ready_o  (buf_ready),
    .in_data_i   (entry_in),
    .out_valid_o (entry_valid),
    .out_ready_i (drain_ok),
    .out_data_o  (entry_out)
  );

  // Array writes stall in sleep; the buffer absorbs up to two words
  assign drain_ok = !sleep_request_i;

  generate
    for (g = 0; g < `SFSP_LANES; g = g + 1) begin : g_bits
      // Lane g owns data byte g and parity bit g
      assign lane_bits[g*`SFSP_LANE_W +: `SFSP_LANE_W] =
        {`SFSP_LANE_W{entry_out[`SFSP_WORD_W+g]}};
      assign lane_bits[`SFSP_DW+g] = entry_out[`SFSP_WORD_W+g];
    end
  endgenerate

  always @(posedge clk_i) begin
    if (entry_valid && drain_ok) begin
      mem_q[entry_out[`SFSP_ENTRY_W-1:`SFSP_WORD_W+`SFSP_LANES]] <=
        (mem_q[entry_out[`SFSP_ENTRY_W-1:`SFSP_WORD_W+`SFSP_LANES]] & ~lane_bits) |
        (entry_out[`SFSP_WORD_W-1:0] & lane_bits);
    end
  end

  // ----------------------------------------------------------------
  // Port registers
  // ----------------------------------------------------------------
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= `SFSP_ST_DESEL;
      addr_q  <= {`SFSP_AW{1'h0}};
      step_q  <= `SFSP_CNT_ZERO;
      mode_q  <= `SFSP_MODE_ILV;
      dout_q  <= {`SFSP_WORD_W{1'h0}};
      oe_q    <= 1'h0;
      sleep_q <= 1'h0;
    end else begin
      state_q <= state_d;
      addr_q  <= addr_d;
      step_q  <= step_d;
      mode_q  <= burst_order_strap_i;
      sleep_q <= sleep_request_i;
      if (!sleep_request_i) begin
        dout_q <= mem_q[eff_addr[`SFSP_MEM_AW-1:0]];
      end
      // Released when deselected, on the first selected clock and for writes
      oe_q <= (state_d == `SFSP_ST_ACTIVE) && (state_q == `SFSP_ST_ACTIVE) &&
              !out_enable_n_i && !write_now && !sleep_request_i;
    end
  end

  assign dq_o           = dout_q[`SFSP_DW-1:0];
  assign parity_io_o    = dout_q[`SFSP_WORD_W-1:`SFSP_DW];
  assign dq_oe_o        = oe_q;
  assign parity_io_oe_o = oe_q;
  assign write_ready_o  = buf_ready;
  assign selected_o     = state_q;
  assign sleeping_o     = sleep_q;

endmodule

// >>> test/sfsp_port_props.sv
/*
  Checker of the SRAM port's output-enable, select and sleep behaviour.
  Assumes it is bound to sfsp_port and sees only its ports.
*/
`timescale 1ns/1ps
module sfsp_port_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic processor_addr_strobe_n_i,
  input wire logic controller_addr_strobe_n_i,
  input wire logic primary_select_n_i,
  input wire logic secondary_select_i,
  input wire logic tertiary_select_n_i,
  input wire logic all_bytes_write_n_i,
  input wire logic byte_write_qualifier_n_i,
  input wire logic out_enable_n_i,
  input wire logic sleep_request_i,
  input wire logic dq_oe_o,
  input wire logic parity_io_oe_o,
  input wire logic selected_o,
  input wire logic sleeping_o
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire en3 = !primary_select_n_i && secondary_select_i && !tertiary_select_n_i;
  wire calm = processor_addr_strobe_n_i && controller_addr_strobe_n_i;
  oe_pair_a: assert property (dq_oe_o == parity_io_oe_o)
    else $error("parity enable differs from data enable");
  oe_off_a: assert property (out_enable_n_i |=> !dq_oe_o)
    else $error("driving with output enable high");
  desel_off_a: assert property (!selected_o |=> !dq_oe_o)
    else $error("driving while or just after deselected");
  sleep_off_a: assert property (sleep_request_i |=> sleeping_o && !dq_oe_o)
    else $error("sleep not entered");
  proc_ign_a: assert property (selected_o && primary_select_n_i
    && !processor_addr_strobe_n_i && controller_addr_strobe_n_i |=> selected_o)
    else $error("processor strobe not ignored");
  proc_sel_a: assert property (!processor_addr_strobe_n_i && en3 |=> selected_o)
    else $error("processor strobe did not select");
  ctrl_sel_a: assert property (!controller_addr_strobe_n_i && en3 |=> selected_o)
    else $error("controller strobe did not select");
  read_on_a: assert property (selected_o && calm && !out_enable_n_i && !sleep_request_i
    && all_bytes_write_n_i && byte_write_qualifier_n_i |=> dq_oe_o)
    else $error("read data not driven");
endmodule
bind sfsp_port sfsp_port_chk u_chk (.clk_i, .rst_i, .processor_addr_strobe_n_i,
  .controller_addr_strobe_n_i, .primary_select_n_i, .secondary_select_i,
  .tertiary_select_n_i, .all_bytes_write_n_i, .byte_write_qualifier_n_i, .out_enable_n_i,
  .sleep_request_i, .dq_oe_o, .parity_io_oe_o, .selected_o, .sleeping_o);

// >>> test/sfsp_host_pins.sv
/*
  Host-side pin model: resolves the shared data wire and the strap pulls.
  Assumes the host drives data only while the port is not driving.
*/
`timescale 1ns/1ps
module sfsp_host_pins (
  input  wire logic        clk_i,
  input  wire logic        dev_oe_i,
  input  wire logic        host_en_i,
  input  wire logic        sleep_en_i,
  input  wire logic        sleep_d_i,
  input  wire logic        strap_en_i,
  input  wire logic        strap_d_i,
  input  wire logic [17:0] dev_d_i,
  input  wire logic [17:0] host_d_i,
  output wire logic [17:0] pin_d_o,
  output wire logic        sleep_o,
  output wire logic        strap_o
);
  // ----------------------------------------------------------------
  // Wire resolution
  // ----------------------------------------------------------------
  logic [17:0] last_q = 18'h0;
  always @(posedge clk_i) if (dev_oe_i || host_en_i) last_q <= pin_d_o;
  // Floating bus shows inverted history
  assign pin_d_o = dev_oe_i ? dev_d_i : (host_en_i ? host_d_i : ~last_q);
  assign sleep_o = sleep_en_i ? sleep_d_i : 1'b0;
  assign strap_o = strap_en_i ? strap_d_i : 1'b1;
endmodule

// >>> test/sfsp_port_tb.sv
/*
  Self-checking bench of the SRAM port: burst writes, sleep fill, reads.
  Assumes the host pin model and the bound checker.
*/
`timescale 1ns/1ps
module sfsp_port_tb;
  // ----------------------------------------------------------------
  // Stimulus and model
  // ----------------------------------------------------------------
  logic clk_i = 0, rst_i = 1, ps = 1, cs = 1, st = 1, p1 = 0, s2 = 1, gw = 1, byte_write_qualifier_n = 1;
  logic oen = 1, hen = 0, slp = 0, slpe = 0, md = 0, mde = 1, ilv = 0;
  logic [1:0] ln = 2'h3;
  logic [19:0] a = 20'h0, base = 20'h0;
  logic [17:0] hd = 18'h0;
  logic [17:0] mem [0:1023];
  logic [17:0] q [$];
  wire [17:0] dw;
  wire [15:0] dq_o;
  wire [1:0] pr_o;
  wire oe, wr, slw, stw;
  int n_errors = 0, tests_run = 0, seed = 12;
  always #12.5 clk_i = ~clk_i;
  sfsp_port u_dut (.clk_i, .rst_i, .addr_i(a), .processor_addr_strobe_n_i(ps),
    .controller_addr_strobe_n_i(cs), .burst_step_n_i(st), .primary_select_n_i(p1),
    .secondary_select_i(s2), .tertiary_select_n_i(1'b0), .all_bytes_write_n_i(gw),
    .byte_write_qualifier_n_i(byte_write_qualifier_n), .byte_lane_write_n_i(ln), .out_enable_n_i(oen),
    .sleep_request_i(slw), .burst_order_strap_i(stw), .dq_i(dw[15:0]), .dq_o(dq_o),
    .dq_oe_o(oe), .parity_io_i(dw[17:16]), .parity_io_o(pr_o), .parity_io_oe_o(),
    .write_ready_o(wr), .selected_o(), .sleeping_o());
  sfsp_host_pins u_pins (.clk_i, .dev_oe_i(oe), .host_en_i(hen), .sleep_en_i(slpe),
    .sleep_d_i(slp), .strap_en_i(mde), .strap_d_i(md), .dev_d_i({pr_o, dq_o}),
    .host_d_i(hd), .pin_d_o(dw), .sleep_o(slw), .strap_o(stw));
  task tick; @(negedge clk_i); endtask
  task chk(input string n, input logic [17:0] s, input logic [17:0] e);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask
  task results;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  function automatic [9:0] e(input int k);
    e = {base[9:2], ilv ? base[1:0] ^ k[1:0] : base[1:0] + k[1:0]};
  endfunction
  task automatic wburst(input logic z);
    slp = z; slpe = z; hen = 1; cs = 0; a = base; gw = z; byte_write_qualifier_n = !z;
    for (int k = 0; k < 4; k++) begin
      if (k > 0) begin
        cs = 1; st = 0;
      end
      // Lanes never all off, so every cycle of a burst requests a write
      hd = $random(seed); ln = {$random(seed)} % 3;
      if (z && k == 2) chk("ready", 18'(wr), 18'h0);
      if (wr === 1'b1 && !gw) mem[e(k)] = hd;
      if (wr === 1'b1 && gw && !ln[0]) {mem[e(k)][16], mem[e(k)][7:0]} = {hd[16], hd[7:0]};
      if (wr === 1'b1 && gw && !ln[1]) {mem[e(k)][17], mem[e(k)][15:8]} = {hd[17], hd[15:8]};
      tick;
    end
    st = 1; gw = 1; byte_write_qualifier_n = 1; hen = 0; slp = 0; slpe = 0;
    repeat (3) tick;
    chk("ready", 18'(wr), 18'h1);
  endtask
  task rburst;
    p1 = 1; ps = 0; tick;
    ps = 1; cs = 0; s2 = 0; oen = 0; tick;
    p1 = 0; s2 = 1; a = base; tick;
    cs = 1; ps = 0; q.push_back(mem[e(0)]); tick;
    ps = 1; st = 0;
    for (int k = 1; k < 5; k++) begin
      q.push_back(mem[e(k)]); tick;
    end
    st = 1; oen = 1;
  endtask
  always @(posedge clk_i) begin
    #1;
    if (!rst_i && oe === 1'b1) begin
      if (q.size() > 0) chk("read", {pr_o, dq_o}, q.pop_front());
      else chk("extra", 18'h1, 18'h0);
    end
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    n_errors++;
    results;
  end
  initial begin
    repeat (3) tick;
    rst_i = 0;
    for (int m = 0; m < 2; m++) begin
      if (m == 1) begin
        // Strap changes only while the port is held in reset
        rst_i = 1; ilv = 1; mde = 0;
        repeat (3) tick;
        rst_i = 0;
      end
      base = $random(seed);
      wburst(1'b0);
      if (m == 0) wburst(1'b1);
      rburst;
    end
    repeat (3) tick;
    chk("left", 18'(q.size()), 18'h0);
    results;
  end
endmodule
